/* File: tlic_core.sv */
// Two-level interrupt controller with register port and core vector request
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tlic_defs.svh"
module tlic_core #(
  parameter int N_SRC = 8,
  parameter int EXT_N = 4
) (
  input wire logic ref_clk_i, // Core clock, 250 MHz
  input wire logic nrst_i, // Async reset, active low
  input wire logic [3:0] reg_addr_i, // Register index
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic [EXT_N-1:0] ext_pin_i, // Asynchronous event pins
  input wire logic [N_SRC-EXT_N-1:0] periph_evt_i, // Peripheral event pulses
  input wire logic ret_i, // Core executed return_from_handler_op
  output tlic_pkg::tlic_vec_t vec_o // Push and vector load request
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [EXT_N-1:0] pin_s1, pin_s2, pin_s3;
  logic [1:0] div, next_div;
  logic instr_en;
  logic [N_SRC-1:0] flag, next_flag, enable, next_enable, prio, next_prio, src_set, pend, per_mask;
  logic [EXT_N-1:0] edge_sel, next_edge_sel, ext_ev;
  logic prio_feat, next_prio_feat, glob_hi, next_glob_hi, glob_lo, next_glob_lo;
  logic in_high, next_in_high, in_low, next_in_low;
  tlic_pkg::tlic_state_t state, next_state;
  logic [2:0] lat_cnt, next_lat_cnt;
  logic hi_req, lo_req, take_now;
  logic [7:0] next_rdata;
  tlic_pkg::tlic_vec_t next_vec;

  // Zero-extends a source vector onto the 8-bit data bus
  function automatic logic [7:0] fit8(input logic [N_SRC-1:0] v);
    logic [7:0] r;
    r = '0;
    r[N_SRC-1:0] = v;
    return r;
  endfunction : fit8

  // ------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ------------------------------------------------------------
  // Three stages; only stages two and three are compared
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= ext_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Event on a settled change towards the selected level
  assign ext_ev = (pin_s2 ^ pin_s3) & ~(pin_s2 ^ edge_sel);
  assign src_set = {periph_evt_i, ext_ev};
  assign per_mask = {{(N_SRC-EXT_N){1'b1}}, {EXT_N{1'b0}}};
  assign instr_en = (div == 2'(`TLIC_INSTR_CLKS - 1));

  // ------------------------------------------------------------
  // Request qualification
  // ------------------------------------------------------------
  // Pending sources, then gating by mode
  always_comb begin
    pend = flag & enable;
    if (prio_feat) begin
      hi_req = glob_hi & (|(pend & prio));
      lo_req = glob_lo & (|(pend & ~prio)) & ~in_high;
    end else begin
      // Priority bits ignored, peripherals behind bit 6
      hi_req = glob_hi & (|(pend & ~(per_mask & {N_SRC{~glob_lo}})));
      lo_req = 1'b0;
    end
  end

  assign take_now = (state == tlic_pkg::ST_WAIT) && instr_en &&
                    (lat_cnt == 3'(`TLIC_LAT_INSTR - 1)) && (hi_req || lo_req);

  // ------------------------------------------------------------
  // Registers, sequencer and vector request
  // ------------------------------------------------------------
  // Software writes first, then hardware take and return win
  always_comb begin
    next_div = instr_en ? 2'h0 : div + 2'h1;
    next_flag = flag;
    next_enable = enable;
    next_prio = prio;
    next_edge_sel = edge_sel;
    next_prio_feat = prio_feat;
    next_glob_hi = glob_hi;
    next_glob_lo = glob_lo;
    next_in_high = in_high;
    next_in_low = in_low;
    next_state = state;
    next_lat_cnt = lat_cnt;
    next_vec = '0;
    next_rdata = 8'h00;
    if (reg_wr_i) begin
      if (reg_addr_i == `TLIC_A_RESET_CTL) begin
        next_prio_feat = reg_wdata_i[`TLIC_B_PRIO_FEAT];
      end else if (reg_addr_i == `TLIC_A_INT_CTL) begin
        next_glob_hi = reg_wdata_i[`TLIC_B_GLOB_HI];
        next_glob_lo = reg_wdata_i[`TLIC_B_GLOB_LO];
      end else if (reg_addr_i == `TLIC_A_FLAG) begin
        next_flag = reg_wdata_i[N_SRC-1:0];
      end else if (reg_addr_i == `TLIC_A_ENABLE) begin
        next_enable = reg_wdata_i[N_SRC-1:0];
      end else if (reg_addr_i == `TLIC_A_PRIO) begin
        next_prio = reg_wdata_i[N_SRC-1:0];
      end else if (reg_addr_i == `TLIC_A_EDGE) begin
        next_edge_sel = reg_wdata_i[EXT_N-1:0];
      end
    end
    // Event set beats a software clear in the same cycle
    next_flag = next_flag | src_set;
    if (reg_rd_i) begin
      if (reg_addr_i == `TLIC_A_RESET_CTL) begin
        next_rdata = {prio_feat, 7'h00};
      end else if (reg_addr_i == `TLIC_A_INT_CTL) begin
        next_rdata = {glob_hi, glob_lo, 6'h00};
      end else if (reg_addr_i == `TLIC_A_FLAG) begin
        next_rdata = fit8(flag);
      end else if (reg_addr_i == `TLIC_A_ENABLE) begin
        next_rdata = fit8(enable);
      end else if (reg_addr_i == `TLIC_A_PRIO) begin
        next_rdata = fit8(prio);
      end else if (reg_addr_i == `TLIC_A_EDGE) begin
        next_rdata = {{(8-EXT_N){1'b0}}, edge_sel};
      end else if (reg_addr_i == `TLIC_A_STATUS) begin
        next_rdata = {4'h0, state == tlic_pkg::ST_WAIT, lo_req, in_low, in_high};
      end
    end
    // Return re-arms the level whose handler is ending
    if (ret_i) begin
      if (in_high) begin
        next_in_high = 1'b0;
        next_glob_hi = 1'b1;
      end else if (in_low) begin
        next_in_low = 1'b0;
        next_glob_lo = 1'b1;
      end else begin
        next_glob_hi = 1'b1;
      end
    end
    // Counting divider boundaries, one every TLIC_INSTR_CLKS clocks, takes the vector 9 to 12 clocks after entering wait
    case (state)
      tlic_pkg::ST_IDLE: begin
        next_lat_cnt = 3'h0;
        if (hi_req || lo_req) begin
          next_state = tlic_pkg::ST_WAIT;
        end
      end
      tlic_pkg::ST_WAIT: begin
        if (!(hi_req || lo_req)) begin
          next_state = tlic_pkg::ST_IDLE;
        end else if (take_now) begin
          next_state = tlic_pkg::ST_IDLE;
          next_vec.take = 1'b1;
          if (hi_req) begin
            next_vec.high = 1'b1;
            next_vec.addr = `TLIC_VEC_HIGH;
            next_glob_hi = 1'b0;
            next_in_high = 1'b1;
          end else begin
            next_vec.addr = `TLIC_VEC_LOW;
            next_glob_lo = 1'b0;
            next_in_low = 1'b1;
          end
        end else if (instr_en) begin
          next_lat_cnt = lat_cnt + 3'h1;
        end
      end
      default: begin
        next_state = tlic_pkg::ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div <= 2'h0;
      flag <= '0;
      enable <= '0;
      prio <= N_SRC'(`TLIC_RST_PRIO);
      edge_sel <= EXT_N'(`TLIC_RST_EDGE);
      prio_feat <= 1'b0;
      glob_hi <= 1'b0;
      glob_lo <= 1'b0;
      in_high <= 1'b0;
      in_low <= 1'b0;
      state <= tlic_pkg::ST_IDLE;
      lat_cnt <= 3'h0;
      vec_o <= '0;
      reg_rdata_o <= 8'h00;
    end else begin
      div <= next_div;
      flag <= next_flag;
      enable <= next_enable;
      prio <= next_prio;
      edge_sel <= next_edge_sel;
      prio_feat <= next_prio_feat;
      glob_hi <= next_glob_hi;
      glob_lo <= next_glob_lo;
      in_high <= next_in_high;
      in_low <= next_in_low;
      state <= next_state;
      lat_cnt <= next_lat_cnt;
      vec_o <= next_vec;
      reg_rdata_o <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_vec_high;
    vec_o.take && vec_o.high |-> vec_o.addr == `TLIC_VEC_HIGH;
  endproperty
  a_vec_high: assert property (p_vec_high) else $error("high vector address wrong");

  property p_vec_low;
    vec_o.take && !vec_o.high |-> vec_o.addr == `TLIC_VEC_LOW && $past(prio_feat);
  endproperty
  a_vec_low: assert property (p_vec_low) else $error("low vector wrong or taken without priority");

  property p_compat_single;
    !$past(prio_feat) && vec_o.take |-> vec_o.addr == `TLIC_VEC_HIGH;
  endproperty
  a_compat_single: assert property (p_compat_single) else $error("compat take not at high vector");

  property p_clear_enable;
    vec_o.take |-> (vec_o.high ? !glob_hi : !glob_lo);
  endproperty
  a_clear_enable: assert property (p_clear_enable) else $error("global enable not cleared on take");

  property p_no_low_in_high;
    vec_o.take && !vec_o.high |-> !$past(in_high);
  endproperty
  a_no_low_in_high: assert property (p_no_low_in_high) else $error("low taken during high handler");

  property p_flag_set;
    (|src_set) |=> ((flag & $past(src_set)) == $past(src_set));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set its flag");

  property p_return;
    ret_i && in_high && !take_now |=> glob_hi && !in_high;
  endproperty
  a_return: assert property (p_return) else $error("return did not re-enable high level");

  property p_lat_min;
    $rose(state == tlic_pkg::ST_WAIT) |-> !vec_o.take [*8];
  endproperty
  a_lat_min: assert property (p_lat_min) else $error("vector taken too early");

  property p_lat_max;
    $rose(state == tlic_pkg::ST_WAIT) |-> ##[1:12] (vec_o.take || state == tlic_pkg::ST_IDLE);
  endproperty
  a_lat_max: assert property (p_lat_max) else $error("vector latency too long");

  property p_high_first;
    vec_o.take && !vec_o.high |-> !$past(hi_req);
  endproperty
  a_high_first: assert property (p_high_first) else $error("low taken while high eligible");

  c_take_high: cover property (vec_o.take && vec_o.high && prio_feat);
  c_take_low: cover property (vec_o.take && !vec_o.high);
  c_preempt: cover property (vec_o.take && vec_o.high && in_low);
  c_compat: cover property (vec_o.take && !prio_feat);

endmodule : tlic_core
`default_nettype wire

/* File: tlic_defs.svh */
// Constants for the two-level interrupt controller
`ifndef TLIC_DEFS_SVH
`define TLIC_DEFS_SVH
// ------------------------------------------------------------
// Register indices on the plain register port
// ------------------------------------------------------------
`define TLIC_A_RESET_CTL 4'h0
`define TLIC_A_INT_CTL 4'h1
`define TLIC_A_FLAG 4'h2
`define TLIC_A_ENABLE 4'h3
`define TLIC_A_PRIO 4'h4
`define TLIC_A_EDGE 4'h5
`define TLIC_A_STATUS 4'h6
// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define TLIC_B_PRIO_FEAT 7
`define TLIC_B_GLOB_HI 7
`define TLIC_B_GLOB_LO 6
`define TLIC_RST_EDGE 8'hFF
`define TLIC_RST_PRIO 8'hFF
// ------------------------------------------------------------
// Vectors and timing
// ------------------------------------------------------------
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018
`define TLIC_CLK_NS 4
`define TLIC_INSTR_NS 16
`define TLIC_INSTR_CLKS (`TLIC_INSTR_NS / `TLIC_CLK_NS)
// Boundaries counted in wait; with pin sync and flag set the vector lands within four instruction cycles
`define TLIC_LAT_INSTR 3
`endif

/* File: tlic_pkg.sv */
// Types shared by the two-level interrupt controller
package tlic_pkg;
  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } tlic_state_t;
  // Vector request towards the core sequencer
  typedef struct packed {
    logic take;
    logic high;
    logic [15:0] addr;
  } tlic_vec_t;
endpackage : tlic_pkg

/* File: tlic_core_model.sv */
// Behavioural core sequencer that answers the controller's vector requests
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
  input wire logic ref_clk_i, // Core clock
  input wire logic nrst_i, // Async reset, active low
  input wire tlic_pkg::tlic_vec_t vec_i, // Vector request
  input wire logic ret_req_i, // Bench orders a return
  output logic ret_o, // Return pulse to controller
  output logic [3:0] depth_o // Return addresses held
);
  // ----------------------------------------
  // Stack and return
  // ----------------------------------------
  // Bench picks when to return, so handlers can be short or long
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ret_o <= 1'b0;
      depth_o <= 4'h0;
    end else begin
      ret_o <= ret_req_i;
      depth_o <= depth_o + 4'(vec_i.take) - 4'(ret_req_i);
    end
  end
endmodule : tlic_core_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "tlic_defs.svh"
module tb_top;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [3:0] pevt = 4'h0;
  logic ret_req = 1'b0;
  logic [7:0] rdata;
  logic ret;
  logic [3:0] depth;
  tlic_pkg::tlic_vec_t vec;
  int miscompares = 0;
  int comparisons = 0;
  // 4 ns period
  always #2 ref_clk_i = ~ref_clk_i;
  tlic_core uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ext_pin_i(pins), .periph_evt_i(pevt),
    .ret_i(ret), .vec_o(vec));
  tlic_core_model core_model (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .vec_i(vec),
    .ret_req_i(ret_req), .ret_o(ret), .depth_o(depth));
  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  // Data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), {8'h00, exp}, {8'h00, rdata});
  endtask : rd_reg
  task automatic pulse(input logic [3:0] m, input logic r);
    @(posedge ref_clk_i);
    pevt <= m;
    ret_req <= r;
    @(posedge ref_clk_i);
    pevt <= 4'h0;
    ret_req <= 1'b0;
  endtask : pulse
  // Bounded wait; a missing vector ends the run
  task automatic wait_take(input logic [15:0] va, input logic hi, input int lo_n, input int hi_n);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while (vec.take !== 1'b1 && n < 40);
    if (vec.take !== 1'b1) begin
      miscompares++;
      $display("MISMATCH vector take expected 1 seen 0");
      close_out();
    end else begin
      chk("vector addr", va, vec.addr);
      chk("vector high", {15'h0, hi}, {15'h0, vec.high});
      chk("latency", 16'h1, {15'h0, n >= lo_n && n <= hi_n});
    end
  endtask : wait_take
  task automatic no_take(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      if (vec.take !== 1'b0)
        seen = 1'b1;
    end
    chk("no vector", 16'h0, {15'h0, seen});
  endtask : no_take
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd_reg(`TLIC_A_RESET_CTL, 8'h00);
    rd_reg(`TLIC_A_INT_CTL, 8'h00);
    rd_reg(`TLIC_A_PRIO, `TLIC_RST_PRIO);
    rd_reg(`TLIC_A_EDGE, 8'h0F);
    rd_reg(4'h7, 8'h00);
    // Compatibility mode, priority bits cleared but ignored
    wr_reg(`TLIC_A_PRIO, 8'h00);
    wr_reg(`TLIC_A_ENABLE, 8'h10);
    wr_reg(`TLIC_A_INT_CTL, 8'h80);
    pulse(4'h1, 1'b0);
    no_take(40);
    rd_reg(`TLIC_A_FLAG, 8'h10);
    wr_reg(`TLIC_A_INT_CTL, 8'hC0);
    wait_take(`TLIC_VEC_HIGH, 1'b1, 1, 24);
    rd_reg(`TLIC_A_INT_CTL, 8'h40);
    chk("stack depth", 16'h1, {12'h0, depth});
    wr_reg(`TLIC_A_FLAG, 8'h00);
    pulse(4'h0, 1'b1);
    rd_reg(`TLIC_A_INT_CTL, 8'hC0);
    // Two levels: low handler preempted by a high pin event
    wr_reg(`TLIC_A_RESET_CTL, 8'h80);
    wr_reg(`TLIC_A_PRIO, 8'hEF);
    wr_reg(`TLIC_A_ENABLE, 8'h11);
    wr_reg(`TLIC_A_INT_CTL, 8'h40);
    pulse(4'h1, 1'b0);
    wait_take(`TLIC_VEC_LOW, 1'b0, 1, 24);
    rd_reg(`TLIC_A_INT_CTL, 8'h00);
    wr_reg(`TLIC_A_INT_CTL, 8'h80);
    @(posedge ref_clk_i);
    pins <= 4'h1;
    wait_take(`TLIC_VEC_HIGH, 1'b1, 12, 16);
    rd_reg(`TLIC_A_INT_CTL, 8'h00);
    rd_reg(`TLIC_A_STATUS, 8'h03);
    chk("stack depth", 16'h2, {12'h0, depth});
    wr_reg(`TLIC_A_FLAG, 8'h00);
    pulse(4'h0, 1'b1);
    rd_reg(`TLIC_A_INT_CTL, 8'h80);
    pulse(4'h0, 1'b1);
    rd_reg(`TLIC_A_INT_CTL, 8'hC0);
    chk("stack depth", 16'h0, {12'h0, depth});
    // Both levels pending at once, enables closed meanwhile; pin 0 now fires on its fall
    wr_reg(`TLIC_A_INT_CTL, 8'h00);
    wr_reg(`TLIC_A_EDGE, 8'h0E);
    rd_reg(`TLIC_A_EDGE, 8'h0E);
    @(posedge ref_clk_i);
    pins <= 4'h0;
    @(posedge ref_clk_i);
    pins <= 4'h1;
    pulse(4'h1, 1'b0);
    no_take(30);
    wr_reg(`TLIC_A_INT_CTL, 8'hC0);
    wait_take(`TLIC_VEC_HIGH, 1'b1, 1, 24);
    no_take(40);
    wr_reg(`TLIC_A_FLAG, 8'h10);
    pulse(4'h0, 1'b1);
    wait_take(`TLIC_VEC_LOW, 1'b0, 1, 24);
    rd_reg(`TLIC_A_INT_CTL, 8'h80);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
